// ==== rtl/ept_timer.sv ====
// Purpose: Eight-bit period timer with prescaler and postscaler
// Assumes: ref_clk_i is the instruction clock; all inputs but the asynchronous resetn_i are synchronous
// Notes:   Register read data stands one cycle after the read strobe
//
// Summary of operation
// - Running count increments from zero per tick
// - Input divider selects divide 1, 4, 16
// - Count compared to match value each cycle
// - Match reloads count with zero next
// - Match clocks 4-bit postscaler; sets flag
// - Count and match registers read/write anytime
// - Reset clears count, match becomes all ones
// - Count or control write clears both scalers
// - Control write leaves count value unchanged
// - Run bit enables counting; cleared stops it
// - Postscale ratio is match divider plus one
// - Postscaler terminal count latches match flag
// - Interrupt only when match enable set
// - Unscaled match output drives capture/compare
// - Timer output offered as serial shift clock
//
// Local design decisions: the plain strobed port and the register offsets.
module ept_timer (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic irq_o,
   output logic match_o,
   output logic shift_clk_o
);

   //------------------------------------------------------------
   // Register decode
   //------------------------------------------------------------
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] count_q, count_d;
   logic [7:0] match_val_q, match_val_d;
   logic [3:0] pre_q, pre_d;
   logic [3:0] post_q, post_d;
   logic flag_q, flag_d;
   logic enable_q, enable_d;
   logic [7:0] rdata_q, rdata_d;
   logic match_q, shift_q, irq_q;

   // Write selects per register
   wire wr_ctrl = wr_i && (addr_i == ept_pkg::OFF_CTRL);
   wire wr_count = wr_i && (addr_i == ept_pkg::OFF_COUNT);
   wire wr_match = wr_i && (addr_i == ept_pkg::OFF_MATCH);
   wire wr_flag = wr_i && (addr_i == ept_pkg::OFF_FLAG);
   wire wr_enable = wr_i && (addr_i == ept_pkg::OFF_ENABLE);

   // Control fields
   wire run = ctrl_q[ept_pkg::RUN_BIT];
   wire [1:0] idiv = ctrl_q[ept_pkg::IDIV_LSB +: 2];
   wire [3:0] mdiv = ctrl_q[ept_pkg::MDIV_LSB +: ept_pkg::MDIV_W];

   //------------------------------------------------------------
   // Prescaler and counter
   //------------------------------------------------------------
   // Terminal count for the selected prescale ratio
   wire [3:0] pre_tc = (idiv == ept_pkg::IDIV_1) ? ept_pkg::PRE_TC_1 :
                       (idiv == ept_pkg::IDIV_4) ? ept_pkg::PRE_TC_4 :
                       ept_pkg::PRE_TC_16;
   wire pre_wrap = (pre_q == pre_tc);
   wire tick = run && pre_wrap;
   // Comparator works every cycle, independent of the tick
   wire hit = (count_q == match_val_q);
   // A match restarts from zero only when a tick would advance,
   // so the count dwells on the match value for a full period
   wire reload = tick && hit;
   wire post_wrap = (post_q == mdiv);
   wire post_fire = reload && post_wrap;
   wire scaler_clr = wr_count || wr_ctrl;

   // Prescaler only counts while running; stopped, it holds unless a count or control write clears it
   assign pre_d = scaler_clr ? 4'h0 :
                  !run ? pre_q :
                  pre_wrap ? 4'h0 : pre_q + 4'h1;
   // Postscaler counts match events up to the selected ratio
   assign post_d = scaler_clr ? 4'h0 :
                   !reload ? post_q :
                   post_wrap ? 4'h0 : post_q + 4'h1;
   // Software write has precedence over counting
   assign count_d = wr_count ? wdata_i :
                    reload ? ept_pkg::COUNT_RST :
                    tick ? count_q + 8'h01 : count_q;
   // Control write touches only control bits, never the count
   assign ctrl_d = wr_ctrl ? (wdata_i & ept_pkg::CTRL_WMASK)
                           : ctrl_q;
   assign match_val_d = wr_match ? wdata_i : match_val_q;

   //------------------------------------------------------------
   // Interrupt flag and enable
   //------------------------------------------------------------
   // Write one clears; a new event in the same cycle wins
   assign flag_d = post_fire || (flag_q && !(wr_flag && wdata_i[0]));
   assign enable_d = wr_enable ? wdata_i[0] : enable_q;

   // Read mux; unmapped offsets read zero
   always_comb begin
      rdata_d = 8'h00;
      if (rd_i) begin
         unique case (addr_i)
            ept_pkg::OFF_CTRL: rdata_d = ctrl_q;
            ept_pkg::OFF_COUNT: rdata_d = count_q;
            ept_pkg::OFF_MATCH: rdata_d = match_val_q;
            ept_pkg::OFF_FLAG: rdata_d = {7'h00, flag_q};
            ept_pkg::OFF_ENABLE: rdata_d = {7'h00, enable_q};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   //------------------------------------------------------------
   // State registers
   //------------------------------------------------------------
   // Reset values for all state
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_q <= ept_pkg::CTRL_RST;
         count_q <= ept_pkg::COUNT_RST;
         match_val_q <= ept_pkg::MATCH_RST;
         pre_q <= 4'h0;
         post_q <= 4'h0;
         flag_q <= 1'b0;
         enable_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         count_q <= count_d;
         match_val_q <= match_val_d;
         pre_q <= pre_d;
         post_q <= post_d;
         flag_q <= flag_d;
         enable_q <= enable_d;
      end
   end

   // Registered outputs
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_q <= 8'h00;
         match_q <= 1'b0;
         shift_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         match_q <= reload;
         shift_q <= shift_q ^ reload;
         irq_q <= flag_d && enable_d;
      end
   end

   assign rdata_o = rdata_q;
   assign match_o = match_q;
   assign shift_clk_o = shift_q;
   assign irq_o = irq_q;

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_reload;
      tick && hit && !wr_count;
   endsequence

   chk_reload_zero: assert property (s_reload |=> count_q == 8'h00)
      else $error("count not cleared after match");
   chk_count_step: assert property (tick && !hit && !wr_count
      |=> count_q == $past(count_q) + 8'h01)
      else $error("count did not step");
   chk_stop_hold: assert property (!run && !wr_count
      |=> count_q == $past(count_q))
      else $error("count moved while stopped");
   chk_ctrl_keep: assert property (wr_ctrl && !tick
      |=> count_q == $past(count_q) && pre_q == 4'h0)
      else $error("control write disturbed count");
   chk_bit7_zero: assert property (ctrl_q[7] == 1'b0)
      else $error("control bit 7 set");
   chk_match_out: assert property (s_reload |=> match_o)
      else $error("match output missing");
   chk_flag_set: assert property (post_fire |=> flag_q)
      else $error("flag not latched");
   chk_irq_gate: assert property (irq_o |-> $past(enable_q || enable_d)
      && $past(flag_d))
      else $error("interrupt without enable");
   chk_div4_gap: assert property (run && idiv == ept_pkg::IDIV_4 && tick
      && !scaler_clr ##1 (!scaler_clr && idiv == ept_pkg::IDIV_4
      && run) [*3] |-> !tick)
      else $error("divide by four too fast");
   chk_write_count: assert property (wr_count
      |=> count_q == $past(wdata_i))
      else $error("count write lost");
   chk_post_ratio: assert property (reload && !post_wrap && !scaler_clr
      |=> post_q == $past(post_q) + 4'h1)
      else $error("postscaler misstep");
endmodule

// ==== include/ept_pkg.sv ====
// Purpose: Shared constants for the eight-bit period timer
// Assumes: Byte-wide registers on a plain strobe port
// Notes:   Offsets of the register map are chosen locally
package ept_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;
   // Register offsets
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_COUNT = 4'h1;
   localparam logic [3:0] OFF_MATCH = 4'h2;
   localparam logic [3:0] OFF_FLAG = 4'h3;
   localparam logic [3:0] OFF_ENABLE = 4'h4;
   // Control fields
   localparam int unsigned IDIV_LSB = 0;
   localparam int unsigned RUN_BIT = 2;
   localparam int unsigned MDIV_LSB = 3;
   localparam int unsigned MDIV_W = 4;
   localparam logic [7:0] CTRL_WMASK = 8'h7f;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] MATCH_RST = 8'hff;
   // Prescale: input divider codes and terminal counts
   localparam logic [1:0] IDIV_1 = 2'h0;
   localparam logic [1:0] IDIV_4 = 2'h1;
   localparam logic [3:0] PRE_TC_1 = 4'h0;
   localparam logic [3:0] PRE_TC_4 = 4'h3;
   localparam logic [3:0] PRE_TC_16 = 4'hf;
endpackage

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the eight-bit period timer
// Assumes: Read data stands in the cycle after the read strobe
// Notes:   Read notes go through a queue to a monitor process
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] AC = ept_pkg::OFF_CTRL;
   localparam logic [3:0] AN = ept_pkg::OFF_COUNT;
   localparam logic [3:0] AM = ept_pkg::OFF_MATCH;
   localparam logic [3:0] AF = ept_pkg::OFF_FLAG;
   localparam logic [3:0] AE = ept_pkg::OFF_ENABLE;
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic rd_q = 1'b0;
   logic [7:0] rdata_o;
   logic irq_o;
   logic match_o;
   logic shift_clk_o;
   logic [7:0] exp_q[$];
   logic [7:0] d;
   logic sc0;
   int fail_count = 0;
   int checks = 0;
   int n;
   int m;
   int r;
   ept_timer i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .irq_o(irq_o), .match_o(match_o),
      .shift_clk_o(shift_clk_o));
   // Free-running 8 ns clock
   always #4 ref_clk_i = ~ref_clk_i;
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
      checks++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic print_verdict();
      if (fail_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Read data only stands one cycle, so the monitor samples it there
   always @(posedge ref_clk_i) begin
      rd_q <= rd_i;
      if (rd_q) begin
         chk("rdata", exp_q.pop_front(), rdata_o);
      end
   end
   task automatic wr(logic [3:0] a, logic [7:0] v);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a, logic [7:0] e);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      exp_q.push_back(e);
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
   endtask
   // Cycles up to the next match pulse; bounded so a dead timer ends
   task automatic wait_match(output int c);
      c = 1;
      @(posedge ref_clk_i);
      while (match_o !== 1'b1) begin
         c++;
         if (c > 2000) begin
            chk("timeout", 8'h00, 8'h01);
            print_verdict();
         end
         @(posedge ref_clk_i);
      end
   endtask
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      d = 8'($urandom(32'h8538));
      repeat (10) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      rd(AC, 8'h00);
      rd(AN, 8'h00);
      rd(AM, 8'hff);
      wr(AC, 8'hff);
      rd(AC, 8'h7f);
      wr(AC, 8'h00);
      wr(AN, d);
      repeat (20) @(posedge ref_clk_i);
      rd(AN, d);
      wr(AC, 8'h78);
      rd(AN, d);
      wr(AM, ~d);
      rd(AM, ~d);
      rd(4'hf, 8'h00);
      // Every divider code, measured between two match pulses
      for (int c = 0; c < 4; c++) begin
         m = $urandom_range(9, 2);
         r = (c == 0) ? 1 : (c == 1) ? 4 : 16;
         wr(AC, 8'h00);
         wr(AM, 8'(m));
         wr(AN, 8'h00);
         wr(AC, 8'(4 + c));
         wait_match(n);
         sc0 = shift_clk_o;
         wait_match(n);
         chk("period", 8'((m + 1) * r), 8'(n));
         chk("shift clk", {7'h0, ~sc0}, {7'h0, shift_clk_o});
      end
      // Every postscale ratio; control writes restart the postscaler
      wr(AE, 8'h01);
      wr(AM, 8'h09);
      for (int k = 0; k < 16; k++) begin
         wr(AC, 8'h00);
         wr(AF, 8'h01);
         wr(AN, 8'h00);
         wr(AC, 8'(k * 8 + 4));
         repeat (k) wait_match(n);
         repeat (3) @(posedge ref_clk_i);
         chk("irq early", 8'h00, {7'h0, irq_o});
         wait_match(n);
         repeat (3) @(posedge ref_clk_i);
         chk("irq due", 8'h01, {7'h0, irq_o});
      end
      // Masking and clearing the sticky flag
      wr(AC, 8'h00);
      wr(AE, 8'h00);
      repeat (2) @(posedge ref_clk_i);
      chk("irq masked", 8'h00, {7'h0, irq_o});
      rd(AF, 8'h01);
      wr(AE, 8'h01);
      repeat (2) @(posedge ref_clk_i);
      chk("irq unmasked", 8'h01, {7'h0, irq_o});
      wr(AF, 8'h01);
      repeat (2) @(posedge ref_clk_i);
      chk("irq cleared", 8'h00, {7'h0, irq_o});
      rd(AF, 8'h00);
      repeat (3) @(posedge ref_clk_i);
      print_verdict();
   end
endmodule
